/* File: hdl/alarm_match.sv */
// Compares time bytes with alarm bytes at each update
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module alarm_match (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic strobe,
    input wire logic [23:0] now_time,
    input wire logic [23:0] alarm_time,
    event_if.match ev
);
    logic [2:0] byte_hit;

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_byte
            assign byte_hit[i] = (alarm_time[8*i+7 -: 2] == `ALARM_DONT_CARE) ||
                                 (alarm_time[8*i+7 -: 8] == now_time[8*i+7 -: 8]);
        end
    endgenerate

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            ev.alarm_pulse <= 1'b0;
        end else begin
            ev.alarm_pulse <= strobe & (&byte_hit);
        end
    end

    alarm_hit_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (strobe && (&byte_hit)) |=> ev.alarm_pulse)
        else $error("matching time gave no alarm pulse");
endmodule

/* File: hdl/event_if.sv */
// Event signals passed from the tap and alarm units to the register core
`timescale 1ns/1ps
interface event_if;
    logic periodic_pulse;
    logic square_level;
    logic alarm_pulse;
    modport tap (output periodic_pulse, output square_level);
    modport match (output alarm_pulse);
    modport core (input periodic_pulse, input square_level, input alarm_pulse);
endinterface

/* File: hdl/rate_tap.sv */
// Divider tap selection feeding the periodic flag and the square wave
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module rate_tap #(
    parameter int STAGES = `DIV_STAGES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [STAGES-1:0] div_stage,
    input wire logic [3:0] rate_select,
    event_if.tap ev
);
    logic [15:0] tap_sel;
    logic tap_level;
    logic tap_q;

    // Code zero disables the output
    assign tap_sel[0] = 1'b0;
    genvar r;
    generate
        for (r = 1; r < 16; r++) begin : g_tap
            assign tap_sel[r] = (rate_select == 4'(r)) & div_stage[`TAP_BASE + r];
        end
    endgenerate
    assign tap_level = |tap_sel;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            tap_q <= 1'b0;
            ev.square_level <= 1'b0;
            ev.periodic_pulse <= 1'b0;
        end else begin
            tap_q <= tap_level;
            ev.square_level <= tap_level;
            ev.periodic_pulse <= tap_q & ~tap_level;
        end
    end

    tap_edge_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
        (tap_q && !tap_level) |=> ev.periodic_pulse)
        else $error("falling tap edge gave no periodic pulse");
endmodule

/* File: hdl/rtc_cfg.svh */
// Register offsets, bit positions and match constants of the clock control block
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

`define ADDR_W 6
`define OFS_CONTROL 6'h0b
`define OFS_FLAGS 6'h0c
`define OFS_STATUS 6'h0d

`define BIT_SET 7
`define BIT_PIE 6
`define BIT_AIE 5
`define BIT_UIE 4
`define BIT_SQUARE_WAVE_ENABLE 3
`define BIT_DM 2
`define BIT_H24 1
`define BIT_DSE 0

`define BIT_INTERRUPT_PENDING_FLAG 7
`define BIT_PF 6
`define BIT_AF 5
`define BIT_UF 4
`define BIT_VALID 7

`define DIV_STAGES 22
`define TAP_BASE 6
`define ALARM_DONT_CARE 2'h3

`define DST_HOUR 8'h01
`define DST_SUNDAY 8'h01
`define DST_APRIL 8'h04
`define DST_59_BCD 8'h59
`define DST_59_BIN 8'h3b
`define DST_OCT_BCD 8'h10
`define DST_OCT_BIN 8'h0a
`define DST_APR_DAY_BCD 8'h24
`define DST_APR_DAY_BIN 8'h18
`define DST_OCT_DAY_BCD 8'h25
`define DST_OCT_DAY_BIN 8'h19

`endif

/* File: hdl/rtc_control_status_irq.sv */
// Control, interrupt-flag and validity-status registers of the real-time clock
`timescale 1ns/1ps
`include "rtc_cfg.svh"

module rtc_control_status_irq
    import rtc_pkg::*;
#(
    parameter int STAGES = `DIV_STAGES
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out,
    output logic ad_oe,
    input wire logic addr_strobe,
    input wire logic data_strobe,
    input wire logic read_not_write,
    input wire logic chip_select_n,
    input wire logic power_sense_input,
    output logic irq_n,
    output logic square_wave_out,
    input wire logic [STAGES-1:0] div_stage,
    input wire logic [3:0] rate_select,
    input wire logic update_done,
    input wire logic [7:0] time_sec,
    input wire logic [7:0] time_min,
    input wire logic [7:0] time_hour,
    input wire logic [7:0] day_of_week,
    input wire logic [7:0] day_of_month,
    input wire logic [7:0] month,
    input wire logic [7:0] alarm_sec,
    input wire logic [7:0] alarm_min,
    input wire logic [7:0] alarm_hour,
    output logic update_allow,
    output logic update_abort,
    output logic data_format_select,
    output logic hour_24_select,
    output logic daylight_saving_enable,
    output logic dst_spring_fwd,
    output logic dst_fall_back
);
    // Pin synchronisers, no reset so reset cannot disturb the validity bit
    logic [12:0] pin_m;
    logic [12:0] pin_s;
    logic [12:0] pin_q;
    logic ps_s, cs_n_s, rw_s, ds_s, as_s;
    logic ps_q, cs_n_q, rw_q, ds_q, as_q;
    logic [7:0] ad_s;
    logic [7:0] ad_q;
    logic as_fall, as_rise, ds_rise, ds_fall;

    bus_state_t bus_state;
    logic [`ADDR_W-1:0] addr_reg;
    byte_t rd_data_reg;
    byte_t read_mux;
    logic addr_hit;
    logic wr_ctrl, rd_flags, rd_status;
    byte_t wdata;

    logic set_reg, pie_reg, aie_reg, uie_reg, square_wave_enable_reg, dm_reg, h24_reg, dse_reg;
    logic pf_reg, af_reg, uf_reg, valid_reg;
    logic interrupt_pending_flag;
    logic update_ev;

    logic [7:0] sixty_last;
    logic at_dst_time, april_last, october_last, is_sunday;
    logic fall_done_reg;

    event_if ev();

    always_ff @(posedge ref_clk) begin
        pin_m <= {power_sense_input, chip_select_n, read_not_write, data_strobe, addr_strobe, ad_in};
        pin_s <= pin_m;
        pin_q <= pin_s;
    end

    assign {ps_s, cs_n_s, rw_s, ds_s, as_s, ad_s} = pin_s;
    assign {ps_q, cs_n_q, rw_q, ds_q, as_q, ad_q} = pin_q;
    assign as_fall = as_q & ~as_s;
    assign as_rise = ~as_q & as_s;
    assign ds_rise = ~ds_q & ds_s;
    assign ds_fall = ds_q & ~ds_s;

    // Multiplexed bus: address latched as the address strobe falls
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            bus_state <= BUS_IDLE;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (as_fall && !cs_n_q) begin
                        bus_state <= BUS_ADDR;
                    end
                end
                BUS_ADDR: begin
                    if (as_rise) begin
                        bus_state <= BUS_IDLE;
                    end else if (ds_rise) begin
                        bus_state <= rw_s ? BUS_READ : BUS_WRITE;
                    end
                end
                BUS_READ, BUS_WRITE: begin
                    if (ds_fall) begin
                        bus_state <= BUS_IDLE;
                    end
                end
                default: begin
                    bus_state <= BUS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            addr_reg <= '0;
        end else if (as_fall) begin
            addr_reg <= ad_q[`ADDR_W-1:0];
        end
    end

    always_comb begin
        addr_hit = 1'b0;
        if (addr_reg == `OFS_CONTROL) begin
            addr_hit = 1'b1;
        end else if (addr_reg == `OFS_FLAGS) begin
            addr_hit = 1'b1;
        end else if (addr_reg == `OFS_STATUS) begin
            addr_hit = 1'b1;
        end
    end

    assign interrupt_pending_flag = (pf_reg & pie_reg) | (af_reg & aie_reg) | (uf_reg & uie_reg);

    always_comb begin
        read_mux = 8'h00;
        if (addr_reg == `OFS_CONTROL) begin
            read_mux = {set_reg, pie_reg, aie_reg, uie_reg, square_wave_enable_reg, dm_reg, h24_reg, dse_reg};
        end else if (addr_reg == `OFS_FLAGS) begin
            read_mux = {interrupt_pending_flag, pf_reg, af_reg, uf_reg, 4'h0};
        end else if (addr_reg == `OFS_STATUS) begin
            read_mux = {valid_reg, 7'h00};
        end
    end

    // Read byte frozen at the data strobe rise; it also marks which flags were seen
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            rd_data_reg <= 8'h00;
        end else if (bus_state == BUS_ADDR && ds_rise && rw_s) begin
            rd_data_reg <= read_mux;
        end
    end

    assign ad_out = rd_data_reg;
    assign ad_oe = (bus_state == BUS_READ) && addr_hit;
    assign wdata = ad_q;
    assign wr_ctrl = (bus_state == BUS_WRITE) && ds_fall && (addr_reg == `OFS_CONTROL);
    assign rd_flags = (bus_state == BUS_READ) && ds_fall && (addr_reg == `OFS_FLAGS);
    assign rd_status = (bus_state == BUS_READ) && ds_fall && (addr_reg == `OFS_STATUS);

    // Fields that neither reset nor internal logic may change
    always_ff @(posedge ref_clk) begin
        if (wr_ctrl) begin
            set_reg <= wdata[`BIT_SET];
            dm_reg <= wdata[`BIT_DM];
            h24_reg <= wdata[`BIT_H24];
            dse_reg <= wdata[`BIT_DSE];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pie_reg <= 1'b0;
            aie_reg <= 1'b0;
            square_wave_enable_reg <= 1'b0;
        end else if (wr_ctrl) begin
            pie_reg <= wdata[`BIT_PIE];
            aie_reg <= wdata[`BIT_AIE];
            square_wave_enable_reg <= wdata[`BIT_SQUARE_WAVE_ENABLE];
        end
    end

    // Setting the inhibit bit in the same write overrides the enable
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            uie_reg <= 1'b0;
        end else if (wr_ctrl) begin
            uie_reg <= wdata[`BIT_UIE] & ~wdata[`BIT_SET];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            update_abort <= 1'b0;
        end else begin
            update_abort <= wr_ctrl & wdata[`BIT_SET];
        end
    end

    assign update_allow = ~set_reg;
    assign data_format_select = dm_reg;
    assign hour_24_select = h24_reg;
    assign daylight_saving_enable = dse_reg;
    assign update_ev = update_done & ~set_reg;

    rate_tap #(
        .STAGES(STAGES)
    ) u_rate_tap (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .div_stage(div_stage),
        .rate_select(rate_select),
        .ev(ev.tap)
    );

    alarm_match u_alarm_match (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .strobe(update_ev),
        .now_time({time_hour, time_min, time_sec}),
        .alarm_time({alarm_hour, alarm_min, alarm_sec}),
        .ev(ev.match)
    );

    // Only flags reported by the read are cleared; a new event sets anyway
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            pf_reg <= 1'b0;
            af_reg <= 1'b0;
            uf_reg <= 1'b0;
        end else begin
            pf_reg <= ev.periodic_pulse | (pf_reg & ~(rd_flags & rd_data_reg[`BIT_PF]));
            af_reg <= ev.alarm_pulse | (af_reg & ~(rd_flags & rd_data_reg[`BIT_AF]));
            uf_reg <= update_ev | (uf_reg & ~(rd_flags & rd_data_reg[`BIT_UF]));
        end
    end

    assign irq_n = ~interrupt_pending_flag;

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            square_wave_out <= 1'b0;
        end else begin
            square_wave_out <= square_wave_enable_reg & ev.square_level;
        end
    end

    // Validity bit ignores the reset pin entirely
    always_ff @(posedge ref_clk) begin
        if (!ps_s) begin
            valid_reg <= 1'b0;
        end else if (rd_status) begin
            valid_reg <= 1'b1;
        end
    end

    // Daylight-saving detection at the update that leaves 1:59:59 AM
    assign sixty_last = dm_reg ? `DST_59_BIN : `DST_59_BCD;
    assign at_dst_time = (time_hour == `DST_HOUR) && (time_min == sixty_last) && (time_sec == sixty_last);
    assign is_sunday = day_of_week == `DST_SUNDAY;
    assign april_last = (month == `DST_APRIL) &&
                        (day_of_month >= (dm_reg ? `DST_APR_DAY_BIN : `DST_APR_DAY_BCD));
    assign october_last = (month == (dm_reg ? `DST_OCT_BIN : `DST_OCT_BCD)) &&
                          (day_of_month >= (dm_reg ? `DST_OCT_DAY_BIN : `DST_OCT_DAY_BCD));

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dst_spring_fwd <= 1'b0;
            dst_fall_back <= 1'b0;
        end else begin
            dst_spring_fwd <= update_ev & dse_reg & is_sunday & april_last & at_dst_time;
            dst_fall_back <= update_ev & dse_reg & is_sunday & october_last & at_dst_time &
                             ~fall_done_reg;
        end
    end

    // Remembers the repeated hour so the fall-back happens only once
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fall_done_reg <= 1'b0;
        end else if (dst_fall_back) begin
            fall_done_reg <= 1'b1;
        end else if (time_hour != `DST_HOUR) begin
            fall_done_reg <= 1'b0;
        end
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    abort_on_set_a: assert property (wr_ctrl && wdata[`BIT_SET] |=> update_abort && !update_allow)
        else $error("inhibit write did not abort and block updates");

    set_kept_a: assert property (!wr_ctrl |=> $stable(set_reg))
        else $error("inhibit bit changed without a write");

    pie_blocks_a: assert property (ev.periodic_pulse && !pie_reg && !aie_reg && !uie_reg
        |=> pf_reg && irq_n)
        else $error("masked periodic flag missing or raised a request");

    reset_clear_a: assert property (@(posedge ref_clk) disable iff (1'b0)
        !rst_n |=> !pie_reg && !aie_reg && !uie_reg && !square_wave_enable_reg)
        else $error("reset left an enable set");

    uie_clear_a: assert property (wr_ctrl && wdata[`BIT_SET] |=> !uie_reg)
        else $error("update enable survived inhibit write");

    sqw_low_a: assert property (!square_wave_enable_reg |=> !square_wave_out)
        else $error("square wave pin not held low");

    sqw_follow_a: assert property (square_wave_enable_reg && $past(square_wave_enable_reg) && ev.square_level |=> square_wave_out)
        else $error("square wave pin does not follow tap");

    spring_fwd_a: assert property (update_ev && dse_reg && is_sunday && april_last && at_dst_time
        |=> dst_spring_fwd)
        else $error("spring jump missed");

    fall_once_a: assert property (dst_fall_back |=> !dst_fall_back [*2])
        else $error("fall back repeated");

    dse_off_a: assert property (!dse_reg |=> !dst_spring_fwd && !dst_fall_back)
        else $error("daylight saving adjustment while disabled");

    irq_enable_a: assert property (ev.alarm_pulse && aie_reg && !wr_ctrl |=> !irq_n)
        else $error("enabled alarm raised no request");

    irq_pin_a: assert property (!irq_n == ((pf_reg && pie_reg) || (af_reg && aie_reg) || (uf_reg && uie_reg)))
        else $error("request pin disagrees with combined flag");

    flag_clear_a: assert property (rd_flags && rd_data_reg[`BIT_UF] && !update_ev |=> !uf_reg)
        else $error("read did not clear update flag");

    update_flag_a: assert property (update_ev |=> uf_reg)
        else $error("update end did not set flag");

    event_kept_a: assert property (rd_flags && ev.periodic_pulse |=> pf_reg)
        else $error("periodic event lost under read");

    low_zero_a: assert property (ad_oe && addr_reg == `OFS_FLAGS |-> ad_out[3:0] == 4'h0)
        else $error("flag register low bits not zero");

    valid_low_a: assert property (!ps_s |=> !valid_reg)
        else $error("validity bit high without power sense");

    valid_set_a: assert property ($rose(valid_reg) |-> $past(rd_status))
        else $error("validity bit set without status read");

    status_zero_a: assert property (ad_oe && addr_reg == `OFS_STATUS |-> ad_out[6:0] == 7'h00)
        else $error("status register low bits not zero");

    cover_flag_read_c: cover property (pf_reg ##1 rd_flags ##1 !pf_reg);
    cover_irq_c: cover property ($fell(irq_n));
    cover_valid_c: cover property ($rose(valid_reg));
    cover_spring_c: cover property (dst_spring_fwd);
endmodule

/* File: hdl/rtc_pkg.sv */
// Types shared by the clock control block
package rtc_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {BUS_IDLE, BUS_ADDR, BUS_READ, BUS_WRITE} bus_state_t;
endpackage

/* File: testbench/bus_master_model.sv */
// Processor model driving the multiplexed address/data bus
`timescale 1ns/1ps
module bus_master_model (
    input wire logic ref_clk,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    output logic [7:0] ad_in,
    output logic addr_strobe,
    output logic data_strobe,
    output logic read_not_write,
    output logic chip_select_n
);
    logic [7:0] drv;
    logic own;
    // Released bus shows the device output while ad_oe is high, else the inverse of the last value
    assign ad_in = own ? drv : (ad_oe ? ad_out : ~drv);
    initial begin
        drv = 8'h00;
        own = 1'b1;
        addr_strobe = 1'b0;
        data_strobe = 1'b0;
        read_not_write = 1'b0;
        chip_select_n = 1'b1;
    end
    task automatic access(input logic rw, input logic [7:0] a, input logic [7:0] wd,
                          output logic [7:0] rd, output logic seen);
        rd = 8'h00;
        seen = 1'b0;
        @(negedge ref_clk);
        own = 1'b1;
        drv = a;
        chip_select_n = 1'b0;
        addr_strobe = 1'b1;
        repeat (4) @(negedge ref_clk);
        addr_strobe = 1'b0;
        repeat (4) @(negedge ref_clk);
        read_not_write = rw;
        own = !rw;
        drv = rw ? drv : wd;
        data_strobe = 1'b1;
        repeat (8) begin
            @(posedge ref_clk);
            if (ad_oe === 1'b1 && !seen) begin
                rd = ad_out;
                seen = 1'b1;
            end
        end
        @(negedge ref_clk);
        data_strobe = 1'b0;
        repeat (5) @(negedge ref_clk);
        own = 1'b1;
        chip_select_n = 1'b1;
        read_not_write = 1'b0;
    endtask
endmodule

/* File: testbench/test_rtc_control_status_irq.sv */
// Self-checking bench for the control, flag and status registers
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module test_rtc_control_status_irq;
    import rtc_pkg::*;
    logic ref_clk, rst_n, ad_oe, addr_strobe, data_strobe, read_not_write, chip_select_n;
    logic power_sense_input, irq_n, square_wave_out, update_done, update_allow, update_abort;
    logic data_format_select, hour_24_select, daylight_saving_enable, dst_spring_fwd, dst_fall_back;
    logic [7:0] ad_in, ad_out, time_sec, time_min, time_hour, day_of_week, day_of_month, month;
    logic [7:0] alarm_sec, alarm_min, alarm_hour;
    logic [`DIV_STAGES-1:0] div_stage;
    logic [3:0] rate_select;
    logic sq_q;
    int miscompares, n_tests, fwd_cnt, back_cnt, abort_cnt, sq_rises;

    rtc_control_status_irq #(.STAGES(`DIV_STAGES)) i_rtc_control_status_irq (.ref_clk, .rst_n, .ad_in,
        .ad_out, .ad_oe, .addr_strobe, .data_strobe, .read_not_write, .chip_select_n, .power_sense_input,
        .irq_n, .square_wave_out, .div_stage, .rate_select, .update_done, .time_sec, .time_min, .time_hour,
        .day_of_week, .day_of_month, .month, .alarm_sec, .alarm_min, .alarm_hour, .update_allow,
        .update_abort, .data_format_select, .hour_24_select, .daylight_saving_enable, .dst_spring_fwd,
        .dst_fall_back);
    bus_master_model i_bus_master_model (.ref_clk, .ad_out, .ad_oe, .ad_in, .addr_strobe, .data_strobe,
        .read_not_write, .chip_select_n);

    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    always @(negedge ref_clk) div_stage <= div_stage + 1'b1;
    always @(posedge ref_clk) begin
        sq_q <= square_wave_out;
        if (square_wave_out === 1'b1 && sq_q === 1'b0) sq_rises <= sq_rises + 1;
        if (dst_spring_fwd === 1'b1) fwd_cnt <= fwd_cnt + 1;
        if (dst_fall_back === 1'b1) back_cnt <= back_cnt + 1;
        if (update_abort === 1'b1) abort_cnt <= abort_cnt + 1;
    end

    task automatic chk8(input byte_t got, input byte_t exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input byte_t a, input byte_t exp);
        byte_t d;
        logic s;
        i_bus_master_model.access(1'b1, a, 8'h00, d, s);
        chk1(s, 1'b1);
        chk8(d, exp);
    endtask
    task automatic wr(input byte_t a, input byte_t d);
        byte_t x;
        logic s;
        i_bus_master_model.access(1'b0, a, d, x, s);
    endtask
    task automatic upd_pulse;
        @(negedge ref_clk);
        update_done = 1'b1;
        @(negedge ref_clk);
        update_done = 1'b0;
        repeat (5) @(negedge ref_clk);
    endtask
    task automatic do_reset;
        @(negedge ref_clk);
        rst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        rst_n = 1'b1;
    endtask
    task automatic stop_test;
        $display("Mismatches %0d in %0d checks", miscompares, n_tests);
        if (miscompares == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    initial begin
        #100000;
        miscompares++;
        stop_test();
    end

    initial begin
        byte_t d;
        logic s;
        {rst_n, power_sense_input, update_done, rate_select, div_stage, sq_q} = '0;
        {miscompares, n_tests, fwd_cnt, back_cnt, abort_cnt, sq_rises} = '0;
        {time_hour, time_min, time_sec} = 24'h123456;
        {day_of_week, day_of_month, month} = 24'h000000;
        {alarm_hour, alarm_min, alarm_sec} = 24'h000000;
        do_reset();
        wr(`OFS_CONTROL, 8'h7f);
        rd_chk(`OFS_CONTROL, 8'h7f);
        do_reset();
        rd_chk(`OFS_CONTROL, 8'h07);
        chk8({data_format_select, hour_24_select, daylight_saving_enable}, 8'h07);
        wr(`OFS_CONTROL, 8'h10);
        wr(`OFS_CONTROL, 8'h90);
        rd_chk(`OFS_CONTROL, 8'h80);
        chk1(update_allow, 1'b0);
        chk1(abort_cnt == 1, 1'b1);
        upd_pulse();
        rd_chk(`OFS_FLAGS, 8'h00);
        wr(`OFS_CONTROL, 8'h10);
        chk1(update_allow, 1'b1);
        upd_pulse();
        chk1(irq_n, 1'b0);
        rd_chk(`OFS_FLAGS, 8'h90);
        chk1(irq_n, 1'b1);
        rd_chk(`OFS_FLAGS, 8'h00);
        // Alarm with hour as don't care, then a minute mismatch
        wr(`OFS_CONTROL, 8'h20);
        {alarm_hour, alarm_min, alarm_sec} = 24'hc03456;
        upd_pulse();
        rd_chk(`OFS_FLAGS, 8'hb0);
        alarm_min = 8'h35;
        upd_pulse();
        rd_chk(`OFS_FLAGS, 8'h10);
        // Periodic flag without and with its enable, square wave on tap
        wr(`OFS_CONTROL, 8'h08);
        rate_select = 4'h1;
        sq_rises = 0;
        repeat (600) @(negedge ref_clk);
        chk1(irq_n, 1'b1);
        chk1(sq_rises >= 2, 1'b1);
        rate_select = 4'h0;
        repeat (4) @(negedge ref_clk);
        rd_chk(`OFS_FLAGS, 8'h40);
        wr(`OFS_CONTROL, 8'h40);
        rate_select = 4'h1;
        sq_rises = 0;
        repeat (300) @(negedge ref_clk);
        chk1(irq_n, 1'b0);
        chk1(sq_rises == 0, 1'b1);
        chk1(square_wave_out, 1'b0);
        rate_select = 4'h0;
        repeat (4) @(negedge ref_clk);
        rd_chk(`OFS_FLAGS, 8'hc0);
        // Daylight saving at 01:59:59 on qualifying Sundays
        wr(`OFS_CONTROL, 8'h01);
        {time_hour, time_min, time_sec} = 24'h015959;
        {day_of_week, day_of_month, month} = 24'h012404;
        upd_pulse();
        chk1(fwd_cnt == 1, 1'b1);
        {day_of_month, month} = 16'h2510;
        upd_pulse();
        upd_pulse();
        chk1(back_cnt == 1, 1'b1);
        wr(`OFS_CONTROL, 8'h00);
        {day_of_month, month} = 16'h2404;
        upd_pulse();
        chk1(fwd_cnt == 1, 1'b1);
        // Binary format uses binary minute, second and date limits
        wr(`OFS_CONTROL, 8'h05);
        {time_min, time_sec, day_of_month} = 24'h3b3b18;
        upd_pulse();
        chk1(fwd_cnt == 2, 1'b1);
        rd_chk(`OFS_FLAGS, 8'h10);
        // Validity bit and unused bits
        rd_chk(`OFS_STATUS, 8'h00);
        power_sense_input = 1'b1;
        repeat (4) @(negedge ref_clk);
        rd_chk(`OFS_STATUS, 8'h00);
        rd_chk(`OFS_STATUS, 8'h80);
        wr(`OFS_STATUS, 8'hff);
        wr(`OFS_FLAGS, 8'hff);
        rd_chk(`OFS_FLAGS, 8'h00);
        do_reset();
        rd_chk(`OFS_STATUS, 8'h80);
        power_sense_input = 1'b0;
        repeat (4) @(negedge ref_clk);
        rd_chk(`OFS_STATUS, 8'h00);
        i_bus_master_model.access(1'b1, 8'h0e, 8'h00, d, s);
        chk1(s, 1'b0);
        stop_test();
    end
endmodule
